// >>> rtl/pec_defs.svh
/*
 * Offsets, field positions, reset values and codes of the port error and
 * status register and the port control register.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH

`define PEC_OFS_ERR_STAT      8'h58
`define PEC_OFS_CTRL          8'h5C

// error and status bit positions
`define PEC_ES_IDLE2_SUP      31
`define PEC_ES_IDLE2_EN       30
`define PEC_ES_IDLE_ACT       29
`define PEC_ES_FC_MODE        27
`define PEC_ES_OUT_RETRY_ENC  20
`define PEC_ES_OUT_RETRIED    19
`define PEC_ES_OUT_RETRY_STOP 18
`define PEC_ES_OUT_ERR_ENC    17
`define PEC_ES_OUT_ERR_STOP   16
`define PEC_ES_IN_RETRY_STOP  10
`define PEC_ES_IN_ERR_ENC     9
`define PEC_ES_IN_ERR_STOP    8
`define PEC_ES_PORT_ERR       2
`define PEC_ES_PORT_OK        1
`define PEC_ES_PORT_UNINIT    0

// control field positions
`define PEC_CT_WIDTH_HI       31
`define PEC_CT_WIDTH_LO       30
`define PEC_CT_INIT_W_HI      29
`define PEC_CT_INIT_W_LO      27
`define PEC_CT_OVR_HI         26
`define PEC_CT_OVR_LO         24
`define PEC_CT_PORT_DIS       23
`define PEC_CT_OUT_EN         22
`define PEC_CT_IN_EN          21
`define PEC_CT_ERR_CHK_DIS    20
`define PEC_CT_MCAST          19
`define PEC_CT_ENUM_BND       17
`define PEC_CT_EXT_OVR_HI     15
`define PEC_CT_EXT_OVR_LO     14
`define PEC_CT_EXT_SUP_HI     13
`define PEC_CT_EXT_SUP_LO     12
`define PEC_CT_PORT_TYPE      0

// reset values
`define PEC_RST_UNINIT        1'b1
`define PEC_RST_MCAST         1'b1
`define PEC_RST_PORT_TYPE     1'b1
`define PEC_RST_EXT           2'b00

// width override codes
`define PEC_OVR_NONE          3'b000
`define PEC_OVR_LANE0         3'b010
`define PEC_OVR_LANER         3'b011

`endif

// >>> rtl/pec_pkg.sv
/*
 * Types shared by the port error and control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pec_pkg;

  // link events, one-cycle pulses from the link layer
  typedef struct packed {
    logic retry_sym;     // packet-retry symbol received
    logic acc_sym;       // packet-accepted symbol received
    logic nacc_sym;      // packet-not-accepted symbol received
    logic out_err;       // output-side error detected
    logic in_err;        // input-side error detected
    logic fatal_err;     // unrecoverable error
    logic out_retry;     // output retry occurred
  } pec_evt_s;

  // link state levels
  typedef struct packed {
    logic       out_retry_stop; // output in retry-stopped state
    logic       out_err_stop;   // output in error-stopped state
    logic       in_retry_stop;  // input waiting for restart-from-retry
    logic       in_err_stop;    // input waiting for link-request
    logic       port_ok;        // initialised, clean symbols exchanged
    logic [2:0] init_width;     // trained link width
  } pec_lvl_s;

  // control levels towards the port
  typedef struct packed {
    logic       port_dis;   // transceivers off
    logic       out_en;     // all packet types may be sent
    logic       in_en;      // all packet types may be accepted
    logic       chk_dis;    // error checking off
    logic       enum_bnd;   // enumeration boundary
    logic [2:0] width_ovr;  // width override code
  } pec_ctl_s;

  typedef enum logic [1:0] {
    PEC_PKT_IDLE,
    PEC_PKT_PASS,
    PEC_PKT_HOLD
  } pec_pkt_e;

endpackage

// >>> rtl/pec_w1c.sv
/*
 * One sticky flag set by a hardware event, cleared by writing one.
 * Assumes set and clear strobes on the same clock as the flag.
 */
`timescale 1ns/1ps

module pec_w1c (
  input  wire logic clock,   // core clock
  input  wire logic rstn,    // async reset, active low
  input  wire logic set_i,   // hardware event
  input  wire logic clr_i,   // software writes one
  output logic      flag_q   // sticky flag
);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

  AST_SET_WINS: assert property (@(posedge clock) disable iff (!rstn)
    set_i |=> flag_q) else $error("sticky flag lost a set");

endmodule // pec_w1c

// >>> rtl/pec_pkt_gate.sv
/*
 * Gates one packet stream by packet type: maintenance always passes,
 * other types pass only while the enable is set.
 * Assumes a request pulse with a maintenance mark and a same-clock enable.
 */
`timescale 1ns/1ps

module pec_pkt_gate
  import pec_pkg::*;
(
  input  wire logic clock,    // core clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic req_i,    // packet offered, one cycle
  input  wire logic maint_i,  // packet is maintenance
  input  wire logic en_i,     // all types allowed
  output logic      pass_q,   // packet let through, pulse
  output logic      hold_q    // packet refused or held, pulse
);
  import pec_pkg::*;

  pec_pkt_e st_d;

  always_comb begin
    st_d = PEC_PKT_IDLE;
    if (req_i) begin
      st_d = (maint_i || en_i) ? PEC_PKT_PASS : PEC_PKT_HOLD;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pass_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      pass_q <= (st_d == PEC_PKT_PASS);
      hold_q <= (st_d == PEC_PKT_HOLD);
    end
  end

  AST_MAINT_PASS: assert property (@(posedge clock) disable iff (!rstn)
    req_i && maint_i |=> pass_q && !hold_q)
    else $error("maintenance packet not passed");

endmodule // pec_pkt_gate

// >>> rtl/pec_port_csr.sv
/*
 * Port error and status register and port control register of one serial
 * port, with the packet gating driven by the enables.
 * Assumes link events are one-cycle pulses and state levels on the core
 * clock; register port is address, strobes, read data one cycle later.
 */
// Our own choice: the strobed register port.
// Summary of operation
// - packet-retry sets retried; accept or not-accept clears
// - output retry-stopped mirrors output state
// - output error sets sticky flag, write one clears
// - output error-stopped high until link-response
// - input retry-stopped high awaiting restart
// - input error sets sticky flag, write one clears
// - input error-stopped high awaiting link-request
// - unrecoverable error sets sticky port-error flag
// - port OK when initialised; uninitialised resets high
// - trained width reported in read-only field
// - override accepts 000, 010, 011 only
// - port-disable turns transceivers off
// - output disabled sends only maintenance packets
// - input disabled refuses non-maintenance with not-accepted
// - error-check-disable bit turns checking off
// - multicast participant always reads one
// - writable enumeration-boundary bit
// - extended width fields tied to zero
// - output retry sets sticky flag, write one clears
`timescale 1ns/1ps
`include "pec_defs.svh"

module pec_port_csr
  import pec_pkg::*;
#(
  parameter logic [1:0] PORT_WIDTH  = 2'b00, // supported width code
  parameter logic [2:0] OVR_RST     = 3'b000, // override reset
  parameter logic       PDIS_RST    = 1'b0,  // port disable reset
  parameter logic       OEN_RST     = 1'b1,  // output enable reset
  parameter logic       IEN_RST     = 1'b1,  // input enable reset
  parameter logic       CHK_RST     = 1'b0,  // check disable reset
  parameter logic       ENUM_RST    = 1'b0,  // enum boundary reset
  parameter logic [3:0] IDLE_FC     = 4'h0   // bits 31,30,29,27
)(
  input  wire logic        clock,        // core clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic [7:0]  addr,         // register byte address
  input  wire logic [31:0] wdata,        // write data
  input  wire logic        wr,           // write strobe
  input  wire logic        rd,           // read strobe
  output logic      [31:0] rdata_q,      // read data, cycle after rd
  input  wire pec_pkg::pec_evt_s evt,    // link event pulses
  input  wire pec_pkg::pec_lvl_s lvl,    // link state levels
  input  wire logic        tx_req,       // outbound packet offered
  input  wire logic        tx_maint,     // outbound is maintenance
  input  wire logic        rx_req,       // inbound packet arrived
  input  wire logic        rx_maint,     // inbound is maintenance
  output logic             tx_pass_q,    // outbound sent, pulse
  output logic             tx_hold_q,    // outbound held back, pulse
  output logic             rx_pass_q,    // inbound accepted, pulse
  output logic             rx_nacc_q,    // send not-accepted, pulse
  output pec_pkg::pec_ctl_s ctl_q,       // control levels
  output logic             xcvr_en_q     // transceivers enabled
);
  import pec_pkg::*;

  // ==========================================================
  // decode
  logic wr_es;
  logic wr_ct;
  assign wr_es = wr && (addr == `PEC_OFS_ERR_STAT);
  assign wr_ct = wr && (addr == `PEC_OFS_CTRL);

  // ==========================================================
  // sticky flags
  logic out_retry_enc_q;
  logic out_err_enc_q;
  logic in_err_enc_q;
  logic port_err_q;

  pec_w1c u_out_retry_enc (
    .clock  (clock),
    .rstn   (rstn),
    .set_i  (evt.out_retry),
    .clr_i  (wr_es && wdata[`PEC_ES_OUT_RETRY_ENC]),
    .flag_q (out_retry_enc_q)
  );
  pec_w1c u_out_err_enc (
    .clock  (clock),
    .rstn   (rstn),
    .set_i  (evt.out_err),
    .clr_i  (wr_es && wdata[`PEC_ES_OUT_ERR_ENC]),
    .flag_q (out_err_enc_q)
  );
  pec_w1c u_in_err_enc (
    .clock  (clock),
    .rstn   (rstn),
    .set_i  (evt.in_err),
    .clr_i  (wr_es && wdata[`PEC_ES_IN_ERR_ENC]),
    .flag_q (in_err_enc_q)
  );
  pec_w1c u_port_err (
    .clock  (clock),
    .rstn   (rstn),
    .set_i  (evt.fatal_err),
    .clr_i  (wr_es && wdata[`PEC_ES_PORT_ERR]),
    .flag_q (port_err_q)
  );

  // ==========================================================
  // output retried
  logic out_retried_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_retried_q <= 1'b0;
    end else if (evt.retry_sym) begin
      out_retried_q <= 1'b1;
    end else if (evt.acc_sym || evt.nacc_sym) begin
      out_retried_q <= 1'b0;
    end
  end

  // ==========================================================
  // state mirrors
  logic       out_rstop_q;
  logic       out_estop_q;
  logic       in_rstop_q;
  logic       in_estop_q;
  logic       port_ok_q;
  logic       uninit_q;
  logic [2:0] init_w_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_rstop_q <= 1'b0;
      out_estop_q <= 1'b0;
      in_rstop_q  <= 1'b0;
      in_estop_q  <= 1'b0;
    end else begin
      out_rstop_q <= lvl.out_retry_stop;
      out_estop_q <= lvl.out_err_stop;
      in_rstop_q  <= lvl.in_retry_stop;
      in_estop_q  <= lvl.in_err_stop;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_ok_q <= 1'b0;
      uninit_q  <= `PEC_RST_UNINIT;
      init_w_q  <= 3'b000;
    end else begin
      port_ok_q <= lvl.port_ok;
      uninit_q  <= !lvl.port_ok;
      init_w_q  <= lvl.init_width;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_q.port_dis  <= PDIS_RST;
      ctl_q.out_en    <= OEN_RST;
      ctl_q.in_en     <= IEN_RST;
      ctl_q.chk_dis   <= CHK_RST;
      ctl_q.enum_bnd  <= ENUM_RST;
      ctl_q.width_ovr <= OVR_RST;
    end else if (wr_ct) begin
      ctl_q.port_dis <= wdata[`PEC_CT_PORT_DIS];
      ctl_q.out_en   <= wdata[`PEC_CT_OUT_EN];
      ctl_q.in_en    <= wdata[`PEC_CT_IN_EN];
      ctl_q.chk_dis  <= wdata[`PEC_CT_ERR_CHK_DIS];
      ctl_q.enum_bnd <= wdata[`PEC_CT_ENUM_BND];
      unique case (wdata[`PEC_CT_OVR_HI:`PEC_CT_OVR_LO])
        `PEC_OVR_NONE,
        `PEC_OVR_LANE0,
        `PEC_OVR_LANER: begin
          ctl_q.width_ovr <= wdata[`PEC_CT_OVR_HI:`PEC_CT_OVR_LO];
        end
        default: begin
          ctl_q.width_ovr <= ctl_q.width_ovr;
        end
      endcase
    end
  end

  // transceivers follow the disable bit one cycle later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      xcvr_en_q <= 1'b0;
    end else begin
      xcvr_en_q <= !ctl_q.port_dis;
    end
  end

  // ==========================================================
  // packet gating
  pec_pkt_gate u_tx_gate (
    .clock   (clock),
    .rstn    (rstn),
    .req_i   (tx_req),
    .maint_i (tx_maint),
    .en_i    (ctl_q.out_en),
    .pass_q  (tx_pass_q),
    .hold_q  (tx_hold_q)
  );
  pec_pkt_gate u_rx_gate (
    .clock   (clock),
    .rstn    (rstn),
    .req_i   (rx_req),
    .maint_i (rx_maint),
    .en_i    (ctl_q.in_en),
    .pass_q  (rx_pass_q),
    .hold_q  (rx_nacc_q)
  );

  // ==========================================================
  // read back
  logic [31:0] es_word;
  logic [31:0] ct_word;

  always_comb begin
    es_word = 32'h0000_0000;
    es_word[`PEC_ES_IDLE2_SUP]      = IDLE_FC[3];
    es_word[`PEC_ES_IDLE2_EN]       = IDLE_FC[2];
    es_word[`PEC_ES_IDLE_ACT]       = IDLE_FC[1];
    es_word[`PEC_ES_FC_MODE]        = IDLE_FC[0];
    es_word[`PEC_ES_OUT_RETRY_ENC]  = out_retry_enc_q;
    es_word[`PEC_ES_OUT_RETRIED]    = out_retried_q;
    es_word[`PEC_ES_OUT_RETRY_STOP] = out_rstop_q;
    es_word[`PEC_ES_OUT_ERR_ENC]    = out_err_enc_q;
    es_word[`PEC_ES_OUT_ERR_STOP]   = out_estop_q;
    es_word[`PEC_ES_IN_RETRY_STOP]  = in_rstop_q;
    es_word[`PEC_ES_IN_ERR_ENC]     = in_err_enc_q;
    es_word[`PEC_ES_IN_ERR_STOP]    = in_estop_q;
    es_word[`PEC_ES_PORT_ERR]       = port_err_q;
    es_word[`PEC_ES_PORT_OK]        = port_ok_q;
    es_word[`PEC_ES_PORT_UNINIT]    = uninit_q;
  end

  always_comb begin
    ct_word = 32'h0000_0000;
    ct_word[`PEC_CT_WIDTH_HI:`PEC_CT_WIDTH_LO] = PORT_WIDTH;
    ct_word[`PEC_CT_INIT_W_HI:`PEC_CT_INIT_W_LO] = init_w_q;
    ct_word[`PEC_CT_OVR_HI:`PEC_CT_OVR_LO] = ctl_q.width_ovr;
    ct_word[`PEC_CT_PORT_DIS]    = ctl_q.port_dis;
    ct_word[`PEC_CT_OUT_EN]      = ctl_q.out_en;
    ct_word[`PEC_CT_IN_EN]       = ctl_q.in_en;
    ct_word[`PEC_CT_ERR_CHK_DIS] = ctl_q.chk_dis;
    ct_word[`PEC_CT_MCAST]       = `PEC_RST_MCAST;
    ct_word[`PEC_CT_ENUM_BND]    = ctl_q.enum_bnd;
    ct_word[`PEC_CT_EXT_OVR_HI:`PEC_CT_EXT_OVR_LO] = `PEC_RST_EXT;
    ct_word[`PEC_CT_EXT_SUP_HI:`PEC_CT_EXT_SUP_LO] = `PEC_RST_EXT;
    ct_word[`PEC_CT_PORT_TYPE]   = `PEC_RST_PORT_TYPE;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd && addr == `PEC_OFS_ERR_STAT) begin
      rdata_q <= es_word;
    end else if (rd && addr == `PEC_OFS_CTRL) begin
      rdata_q <= ct_word;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  AST_RETRIED_SET: assert property (
    @(posedge clock) disable iff (!rstn)
    evt.retry_sym |=> out_retried_q)
    else $error("retried not set");
  AST_RETRIED_CLR: assert property (
    @(posedge clock) disable iff (!rstn)
    !evt.retry_sym && (evt.acc_sym || evt.nacc_sym) |=> !out_retried_q)
    else $error("retried not cleared");
  AST_OUT_RSTOP: assert property (
    @(posedge clock) disable iff (!rstn)
    lvl.out_retry_stop |=> out_rstop_q)
    else $error("retry-stop lost");
  AST_OUT_ERR_SET: assert property (
    @(posedge clock) disable iff (!rstn)
    evt.out_err |=> out_err_enc_q)
    else $error("output error flag not set");
  AST_OUT_ERR_ENC: assert property (
    @(posedge clock) disable iff (!rstn)
    out_err_enc_q && !(wr_es && wdata[`PEC_ES_OUT_ERR_ENC]) |=> out_err_enc_q)
    else $error("output error flag dropped");
  AST_OUT_ESTOP: assert property (
    @(posedge clock) disable iff (!rstn)
    lvl.out_err_stop |=> out_estop_q)
    else $error("output error-stop lost");
  AST_IN_RSTOP: assert property (
    @(posedge clock) disable iff (!rstn)
    lvl.in_retry_stop |=> in_rstop_q)
    else $error("input retry-stop lost");
  AST_IN_ERR_ENC: assert property (
    @(posedge clock) disable iff (!rstn)
    evt.in_err ##1 !(wr_es && wdata[`PEC_ES_IN_ERR_ENC]) |=> in_err_enc_q)
    else $error("input error flag dropped");
  AST_IN_ESTOP: assert property (
    @(posedge clock) disable iff (!rstn)
    lvl.in_err_stop |=> in_estop_q)
    else $error("input error-stop lost");
  AST_PORT_ERR_SET: assert property (
    @(posedge clock) disable iff (!rstn)
    evt.fatal_err |=> port_err_q)
    else $error("port error flag not set");
  AST_PORT_OK: assert property (
    @(posedge clock) disable iff (!rstn)
    port_ok_q |-> !uninit_q)
    else $error("ok and uninit both high");
  AST_UNINIT: assert property (
    @(posedge clock) disable iff (!rstn)
    !lvl.port_ok |=> uninit_q)
    else $error("uninit low before port ok");
  AST_INIT_W: assert property (
    @(posedge clock) disable iff (!rstn)
    1'b1 |=> init_w_q == $past(lvl.init_width))
    else $error("trained width not mirrored");
  AST_OVR_BAD: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_ct && !(wdata[26:24] inside {3'b000, 3'b010, 3'b011})
    |=> $stable(ctl_q.width_ovr))
    else $error("bad override taken");
  AST_XCVR_OFF: assert property (
    @(posedge clock) disable iff (!rstn)
    ctl_q.port_dis [*2] |-> !xcvr_en_q)
    else $error("xcvr on");
  AST_TX_HOLD: assert property (
    @(posedge clock) disable iff (!rstn)
    tx_req && !tx_maint && !ctl_q.out_en |=> tx_hold_q && !tx_pass_q)
    else $error("non-maintenance packet sent");
  AST_RX_NACC: assert property (
    @(posedge clock) disable iff (!rstn)
    rx_req && !rx_maint && !ctl_q.in_en |=> rx_nacc_q)
    else $error("no not-accepted");
  AST_CHK_DIS: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_ct |=> ctl_q.chk_dis == $past(wdata[`PEC_CT_ERR_CHK_DIS]))
    else $error("check disable not written");
  AST_MCAST: assert property (
    @(posedge clock) disable iff (!rstn)
    rd && addr == `PEC_OFS_CTRL |=> rdata_q[19] && rdata_q[15:12] == 4'h0)
    else $error("fixed control bits wrong");
  AST_ENUM_BND: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_ct |=> ctl_q.enum_bnd == $past(wdata[`PEC_CT_ENUM_BND]))
    else $error("enumeration boundary not written");
  AST_RETRY_ENC_SET: assert property (
    @(posedge clock) disable iff (!rstn)
    evt.out_retry |=> out_retry_enc_q)
    else $error("retry flag not set");
  AST_W1C_ZERO: assert property (
    @(posedge clock) disable iff (!rstn)
    port_err_q && wr_es && !wdata[`PEC_ES_PORT_ERR] |=> port_err_q)
    else $error("zero write cleared port error");

endmodule // pec_port_csr

// >>> verification/test_rapidio_port_error_control_csr.sv
/*
 * Self-checking bench for the port error/status and control register bank.
 * Assumes pec_port_csr with default parameters, the pec_pkg types and the
 * pec_defs.svh offsets; the bench drives every port itself.
 */
`timescale 1ns/1ps
`include "pec_defs.svh"

module test_rapidio_port_error_control_csr;
  import pec_pkg::*;

  // ==========================================================================
  // signals
  localparam logic [1:0] port_width = 2'b00;
  logic        clock;
  logic        rstn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_q;
  pec_evt_s    evt;
  pec_lvl_s    lvl;
  logic        tx_req;
  logic        tx_maint;
  logic        rx_req;
  logic        rx_maint;
  logic        tx_pass_q;
  logic        tx_hold_q;
  logic        rx_pass_q;
  logic        rx_nacc_q;
  pec_ctl_s    ctl_q;
  logic        xcvr_en_q;
  pec_ctl_s    exp_c;
  logic [31:0] wd;
  int          err_total;
  int          total_checks;
  int          sb[4] = '{20, 2, 9, 17};
  logic [31:0] lw[5] = '{32'h0004_0001, 32'h0001_0001, 32'h0000_0401,
                         32'h0000_0101, 32'h0000_0002};
  logic [6:0]  rt_evt[6] = '{7'h40, 7'h20, 7'h40, 7'h10, 7'h60, 7'h20};

  pec_port_csr #(.PORT_WIDTH(port_width)) u_dut (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .evt(evt), .lvl(lvl), .tx_req(tx_req),
    .tx_maint(tx_maint), .rx_req(rx_req), .rx_maint(rx_maint),
    .tx_pass_q(tx_pass_q), .tx_hold_q(tx_hold_q), .rx_pass_q(rx_pass_q),
    .rx_nacc_q(rx_nacc_q), .ctl_q(ctl_q), .xcvr_en_q(xcvr_en_q)
  );

  always #10 clock = ~clock;

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk(rdata_q, exp);
  endtask

  task automatic pulse(input pec_evt_s e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= '0;
    #1;
  endtask

  task automatic pkt(input logic m, input logic oen, input logic ien);
    @(posedge clock);
    tx_req   <= 1'b1;
    tx_maint <= m;
    rx_req   <= 1'b1;
    rx_maint <= m;
    @(posedge clock);
    tx_req   <= 1'b0;
    rx_req   <= 1'b0;
    #1;
    chk({tx_pass_q, tx_hold_q}, {oen | m, !(oen | m)});
    chk({rx_pass_q, rx_nacc_q}, {ien | m, !(ien | m)});
  endtask

  function automatic logic [31:0] ctl_word(input pec_ctl_s c,
                                           input logic [2:0] iw);
    return {port_width, iw, c.width_ovr, c.port_dis, c.out_en, c.in_en,
            c.chk_dis, 1'b1, 1'b0, c.enum_bnd, 1'b0, 4'h0, 11'h000, 1'b1};
  endfunction

  // ==========================================================================
  // stimulus
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict();
  end

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    evt = '0;
    lvl = '0;
    tx_req = 1'b0;
    tx_maint = 1'b0;
    rx_req = 1'b0;
    rx_maint = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    // reset values
    exp_c = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'b000};
    rd_chk(`PEC_OFS_ERR_STAT, 32'h0000_0001);
    rd_chk(`PEC_OFS_CTRL, ctl_word(exp_c, 3'b000));
    chk(ctl_q, exp_c);
    chk(xcvr_en_q, 1'b1);
    $display("test reset done");
    // state mirrors and trained width
    for (int k = 0; k < 5; k++) begin
      lvl <= pec_lvl_s'(8'h80 >> k);
      rd_chk(`PEC_OFS_ERR_STAT, lw[k]);
    end
    for (int w = 0; w < 4; w++) begin
      lvl <= {5'b00000, 3'(w)};
      rd_chk(`PEC_OFS_CTRL, ctl_word(exp_c, 3'(w)));
    end
    lvl <= '0;
    wr_reg(`PEC_OFS_ERR_STAT, 32'hFFFF_FFFF);
    rd_chk(`PEC_OFS_ERR_STAT, 32'h0000_0001);
    $display("test mirrors done");
    // sticky flags
    for (int k = 0; k < 4; k++) begin
      pulse(pec_evt_s'(7'h01 << k));
      rd_chk(`PEC_OFS_ERR_STAT, (32'h1 << sb[k]) | 32'h1);
      wr_reg(`PEC_OFS_ERR_STAT, ~(32'h1 << sb[k]));
      rd_chk(`PEC_OFS_ERR_STAT, (32'h1 << sb[k]) | 32'h1);
      wr_reg(`PEC_OFS_ERR_STAT, 32'h1 << sb[k]);
      rd_chk(`PEC_OFS_ERR_STAT, 32'h0000_0001);
    end
    // event and clear in the same cycle: event wins
    @(posedge clock);
    evt   <= pec_evt_s'(7'h04);
    addr  <= `PEC_OFS_ERR_STAT;
    wdata <= 32'h0000_0200;
    wr    <= 1'b1;
    @(posedge clock);
    evt   <= '0;
    wr    <= 1'b0;
    rd_chk(`PEC_OFS_ERR_STAT, 32'h0000_0201);
    wr_reg(`PEC_OFS_ERR_STAT, 32'h0000_0200);
    $display("test sticky done");
    // retried bit: retry sets, accepted or not-accepted clears
    for (int k = 0; k < 6; k++) begin
      pulse(pec_evt_s'(rt_evt[k]));
      wr_reg(`PEC_OFS_ERR_STAT, 32'h0008_0000);
      rd_chk(`PEC_OFS_ERR_STAT, k[0] ? 32'h1 : 32'h0008_0001);
    end
    $display("test retried done");
    // control writes, every override code, read-only bits attacked
    for (int o = 0; o < 8; o++) begin
      wd = {2'b11, 3'b111, 3'(o), o[0], ~o[0], o[1], o[2], 1'b0, 1'b1,
            o[1], 1'b1, 4'hF, 8'hFF, 3'h7, 1'b0};
      exp_c.port_dis = o[0];
      exp_c.out_en   = ~o[0];
      exp_c.in_en    = o[1];
      exp_c.chk_dis  = o[2];
      exp_c.enum_bnd = o[1];
      if (o == 0 || o == 2 || o == 3)
        exp_c.width_ovr = 3'(o);
      wr_reg(`PEC_OFS_CTRL, wd);
      chk(ctl_q, exp_c);
      rd_chk(`PEC_OFS_CTRL, ctl_word(exp_c, 3'b000));
      chk(xcvr_en_q, !exp_c.port_dis);
    end
    $display("test control done");
    // packet gating, all enable and type combinations
    for (int g = 0; g < 8; g++) begin
      wr_reg(`PEC_OFS_CTRL, {9'h000, g[0], g[1], 21'h000000});
      pkt(g[2], g[0], g[1]);
    end
    $display("test gating done");
    // unmapped address, read data lasts one cycle
    exp_c = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'b000};
    wr_reg(8'h60, 32'hFFFF_FFFF);
    rd_chk(8'h60, 32'h0000_0000);
    rd_chk(`PEC_OFS_CTRL, ctl_word(exp_c, 3'b000));
    @(posedge clock);
    #1;
    chk(rdata_q, 32'h0000_0000);
    $display("test unmapped done");
    // second reset in mid-run
    pulse(pec_evt_s'(7'h0F));
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    exp_c = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'b000};
    rd_chk(`PEC_OFS_ERR_STAT, 32'h0000_0001);
    rd_chk(`PEC_OFS_CTRL, ctl_word(exp_c, 3'b000));
    $display("test second reset done");
    print_verdict();
  end

endmodule // test_rapidio_port_error_control_csr
